/* File: hw/ccm_pkg.sv */
// package for the communication channel monitor: register map, fields, codes
package ccm_pkg;
   localparam int unsigned CCM_NCH = 4;
   localparam int unsigned CCM_ETH_CH = 3;
   localparam int unsigned CCM_NPAR = 8;
   localparam logic [7:0] CCM_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CCM_ADDR_STATUS = 8'h04;
   localparam logic [7:0] CCM_ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] CCM_ADDR_IRQ_CLEAR = 8'h0c;
   localparam logic [7:0] CCM_ADDR_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] CCM_ADDR_CODES = 8'h14;
   localparam logic [7:0] CCM_ADDR_REF_FREQ = 8'h18;
   localparam logic [7:0] CCM_ADDR_CTRL_WORD = 8'h1c;
   localparam logic [7:0] CCM_ADDR_INVOLVED = 8'h20;
   localparam logic [7:0] CCM_ADDR_REACTION = 8'h24;
   localparam int unsigned CCM_CTRL_ACTIVE_CH_LSB = 0;
   localparam int unsigned CCM_IRQ_INTERRUPT = 0;
   localparam int unsigned CCM_IRQ_WARNING = 1;
   localparam int unsigned CCM_IRQ_LOCAL_EXIT = 2;
   localparam int unsigned CCM_IRQ_W = 3;
   localparam logic [7:0] CCM_PAR_CTRL_WORD = 8'h01;
   localparam logic [7:0] CCM_PAR_REF_VALUE = 8'h02;
   localparam logic [7:0] CCM_INVOLVED_RESET = 8'h03;
   localparam logic [3:0] CCM_CAUSE_NONE = 4'h0;
   localparam logic [3:0] CCM_CAUSE_TIMEOUT = 4'h1;
   localparam logic [3:0] CCM_EXT_NONE = 4'h0;
   localparam logic [3:0] CCM_EXT_BAD_IP = 4'h1;
   localparam logic [3:0] CCM_EXT_DUP_IP = 4'h2;
   localparam logic [3:0] CCM_EXT_ADDR_SRV = 4'h4;
   typedef enum logic [1:0] {
      CCM_REACT_FAULT = 2'h0,
      CCM_REACT_MAINT = 2'h1,
      CCM_REACT_FALLBACK = 2'h3,
      CCM_REACT_IGNORE = 2'h2
   } ccm_react_t;
   typedef enum logic [1:0] {
      CCM_RUN_IDLE = 2'h0,
      CCM_RUN_ACTIVE = 2'h1,
      CCM_RUN_LOCAL = 2'h3,
      CCM_RUN_WAIT_FRESH = 2'h2
   } ccm_run_t;
endpackage : ccm_pkg

/* File: hw/ccm_monitor.sv */
// channel supervision, enabling and start permission for the drive's command channels
`timescale 1ns/100ps
module ccm_monitor
   import ccm_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic par_wr,
   input wire logic [1:0] par_ch,
   input wire logic [2:0] par_idx,
   input wire logic [15:0] par_data,
   input wire logic eth_addr_srv_fail,
   input wire logic eth_dup_ip,
   input wire logic eth_bad_ip,
   input wire logic eth_word_timeout,
   input wire logic eth_overload,
   input wire logic [CCM_NCH-1:0] ch_warning,
   input wire logic forced_local,
   input wire logic local_run_fwd,
   input wire logic local_run_rev,
   input wire logic [15:0] local_ref_freq,
   input wire logic start_req,
   output logic start_allowed,
   output logic comm_interrupt,
   output logic [1:0] comm_reaction,
   output logic channel_control,
   output logic [15:0] ethernet_control_word,
   output logic [15:0] reference_frequency,
   output logic [3:0] ethernet_interruption_cause,
   output logic [3:0] external_error_code,
   output logic irq
);
   typedef struct packed {
      logic [CCM_NCH-1:0][CCM_NPAR-1:0][15:0] par;
      logic [CCM_NCH-1:0][CCM_NPAR-1:0] written;
      logic [CCM_NCH-1:0][CCM_NPAR-1:0] fresh;
      logic [CCM_NCH-1:0] supervised;
      logic [CCM_NCH-1:0] enabled;
      logic [CCM_NPAR-1:0] involved;
      logic [1:0] active_ch;
      logic [CCM_NCH-1:0] cmd_ref_used;
      ccm_react_t reaction_cfg;
      logic interrupt;
      logic [1:0] reaction;
      ccm_run_t run;
      logic [3:0] cause;
      logic [3:0] ext_code;
      logic [CCM_IRQ_W-1:0] irq_stat;
      logic [CCM_IRQ_W-1:0] irq_en;
      logic [31:0] rdata;
      logic fl_q1;
      logic fl_q2;
      logic [CCM_NCH-1:0] w_q1;
      logic [CCM_NCH-1:0] w_q2;
      logic [4:0] e_q1;
      logic [4:0] e_q2;
   } ccm_state_t;

   ccm_state_t s_q;
   ccm_state_t s_d;
   logic [CCM_NCH-1:0] warn;
   logic [CCM_NCH-1:0] intr_src;
   logic all_enabled;

   always_comb begin
      logic [CCM_IRQ_W-1:0] ev;
      ev = '0;
      s_d = s_q;
      s_d.fl_q1 = forced_local;
      s_d.fl_q2 = s_q.fl_q1;
      s_d.w_q1 = ch_warning;
      s_d.w_q2 = s_q.w_q1;
      s_d.e_q1 = {eth_overload, eth_word_timeout, eth_bad_ip, eth_dup_ip, eth_addr_srv_fail};
      s_d.e_q2 = s_q.e_q1;
      s_d.rdata = '0;
      warn = s_q.w_q2;
      warn[CCM_ETH_CH] = s_q.w_q2[CCM_ETH_CH] | s_q.e_q2[0] | s_q.e_q2[1] | s_q.e_q2[3] | s_q.e_q2[4];
      intr_src = warn & s_q.supervised;
      all_enabled = ((s_q.enabled & s_q.cmd_ref_used) == s_q.cmd_ref_used);
      if (par_wr) begin
         s_d.par[par_ch][par_idx] = par_data;
         s_d.written[par_ch][par_idx] = 1'b1;
         s_d.fresh[par_ch][par_idx] = 1'b1;
         if (s_q.involved[par_idx]) begin
            s_d.supervised[par_ch] = 1'b1;
         end
      end
      for (int c = 0; c < CCM_NCH; c++) begin
         if ((s_d.written[c] & s_q.involved) == s_q.involved && s_d.supervised[c]) begin
            s_d.enabled[c] = 1'b1;
         end
         if (warn[c] || s_q.fl_q2) begin
            s_d.enabled[c] = 1'b0;
         end
      end
      if (|intr_src) begin
         s_d.interrupt = 1'b1;
         s_d.reaction = s_q.reaction_cfg;
         ev[CCM_IRQ_INTERRUPT] = 1'b1;
      end
      if (|warn) begin
         ev[CCM_IRQ_WARNING] = 1'b1;
      end
      // cause tracks timeout on ethernet while interrupted
      s_d.cause = (s_q.interrupt && s_q.e_q2[3]) ? CCM_CAUSE_TIMEOUT : CCM_CAUSE_NONE;
      if (s_q.e_q2[2]) begin
         s_d.ext_code = CCM_EXT_BAD_IP;
      end else if (s_q.e_q2[1]) begin
         s_d.ext_code = CCM_EXT_DUP_IP;
      end else if (s_q.e_q2[0]) begin
         s_d.ext_code = CCM_EXT_ADDR_SRV;
      end else begin
         s_d.ext_code = CCM_EXT_NONE;
      end
      unique case (s_q.run)
         CCM_RUN_IDLE: begin
            // start gate; relies on both words written
            if (start_req && all_enabled && !s_q.interrupt && !s_q.fl_q2) begin
               s_d.run = CCM_RUN_ACTIVE;
            end else if (s_q.fl_q2) begin
               s_d.run = CCM_RUN_LOCAL;
            end
         end
         CCM_RUN_ACTIVE: begin
            if (s_q.fl_q2) begin
               s_d.run = CCM_RUN_LOCAL;
            end else if (!all_enabled) begin
               s_d.run = CCM_RUN_IDLE;
            end
         end
         CCM_RUN_LOCAL: begin
            if (!s_q.fl_q2) begin
               // keep motion: copy local commands into active channel
               s_d.par[s_q.active_ch][0] = {14'h0000, local_run_rev, local_run_fwd};
               s_d.par[s_q.active_ch][1] = local_ref_freq;
               s_d.fresh = '0;
               s_d.run = CCM_RUN_WAIT_FRESH;
               ev[CCM_IRQ_LOCAL_EXIT] = 1'b1;
            end
         end
         CCM_RUN_WAIT_FRESH: begin
            // both words fresh on the active channel
            if (s_q.fresh[s_q.active_ch][0] && s_q.fresh[s_q.active_ch][1] && all_enabled) begin
               s_d.run = CCM_RUN_ACTIVE;
            end else if (s_q.fl_q2) begin
               s_d.run = CCM_RUN_LOCAL;
            end
         end
      endcase
      if (reg_wr) begin
         unique case (reg_addr)
            CCM_ADDR_CTRL: begin
               s_d.active_ch = reg_wdata[CCM_CTRL_ACTIVE_CH_LSB +: 2];
               s_d.cmd_ref_used = reg_wdata[4 +: CCM_NCH];
               if (reg_wdata[8]) begin
                  s_d.interrupt = |intr_src;
               end
            end
            CCM_ADDR_IRQ_CLEAR: s_d.irq_stat = s_q.irq_stat & ~reg_wdata[CCM_IRQ_W-1:0];
            CCM_ADDR_IRQ_ENABLE: s_d.irq_en = reg_wdata[CCM_IRQ_W-1:0];
            CCM_ADDR_INVOLVED: s_d.involved = reg_wdata[CCM_NPAR-1:0];
            CCM_ADDR_REACTION: s_d.reaction_cfg = ccm_react_t'(reg_wdata[1:0]);
            default: begin
            end
         endcase
      end
      // set wins over clear
      s_d.irq_stat = s_d.irq_stat | ev;
      if (reg_rd) begin
         unique case (reg_addr)
            CCM_ADDR_CTRL: s_d.rdata = {20'h00000, 3'h0, s_q.interrupt, s_q.cmd_ref_used, 2'h0, s_q.active_ch};
            CCM_ADDR_STATUS: s_d.rdata = {16'h0000, s_q.run, 2'h0, s_q.enabled, 4'h0, s_q.supervised};
            CCM_ADDR_IRQ_STATUS: s_d.rdata = {29'h0, s_q.irq_stat};
            CCM_ADDR_IRQ_ENABLE: s_d.rdata = {29'h0, s_q.irq_en};
            CCM_ADDR_CODES: s_d.rdata = {24'h000000, s_q.ext_code, s_q.cause};
            CCM_ADDR_REF_FREQ: s_d.rdata = {16'h0000, s_q.par[s_q.active_ch][1]};
            CCM_ADDR_CTRL_WORD: s_d.rdata = {16'h0000, s_q.par[CCM_ETH_CH][0]};
            CCM_ADDR_INVOLVED: s_d.rdata = {24'h000000, s_q.involved};
            CCM_ADDR_REACTION: s_d.rdata = {30'h0, s_q.reaction_cfg};
            default: s_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.involved <= CCM_INVOLVED_RESET;
         s_q.cmd_ref_used <= 4'h8;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign start_allowed = (s_q.run == CCM_RUN_ACTIVE);
   assign comm_interrupt = s_q.interrupt;
   assign comm_reaction = s_q.reaction;
   assign channel_control = (s_q.run == CCM_RUN_ACTIVE);
   assign ethernet_control_word = s_q.par[CCM_ETH_CH][0];
   assign reference_frequency = s_q.par[s_q.active_ch][1];
   assign ethernet_interruption_cause = s_q.cause;
   assign external_error_code = s_q.ext_code;
   assign irq = |(s_q.irq_stat & s_q.irq_en);

   property p_unsup_quiet;
      @(posedge clk) disable iff (!reset_n)
         (!s_q.interrupt && ((warn & s_q.supervised) == '0) && !reg_wr) |=> !s_q.interrupt;
   endproperty
   a_unsup_quiet: assert property (p_unsup_quiet) else $error("interrupt without supervised warning");
   property p_sup_intr;
      @(posedge clk) disable iff (!reset_n)
         (|(warn & s_q.supervised)) |=> s_q.interrupt;
   endproperty
   a_sup_intr: assert property (p_sup_intr) else $error("supervised warning lost");
   property p_warn_disable;
      @(posedge clk) disable iff (!reset_n)
         warn[CCM_ETH_CH] |=> !s_q.enabled[CCM_ETH_CH];
   endproperty
   a_warn_disable: assert property (p_warn_disable) else $error("warned channel still enabled");
   property p_local_disable;
      @(posedge clk) disable iff (!reset_n)
         s_q.fl_q2 |=> (s_q.enabled == '0);
   endproperty
   a_local_disable: assert property (p_local_disable) else $error("channel enabled in local mode");
   property p_start_gate;
      @(posedge clk) disable iff (!reset_n)
         ($rose(start_allowed) && $past(s_q.run) == CCM_RUN_IDLE) |-> $past(all_enabled);
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("start with disabled channel");
   property p_supervise;
      @(posedge clk) disable iff (!reset_n)
         (par_wr && s_q.involved[par_idx]) |=> s_q.supervised[$past(par_ch)];
   endproperty
   a_supervise: assert property (p_supervise) else $error("write did not start supervision");
   property p_fresh_wait;
      @(posedge clk) disable iff (!reset_n)
         (s_q.run == CCM_RUN_LOCAL && !s_q.fl_q2) |=> !channel_control ##1 !channel_control;
   endproperty
   a_fresh_wait: assert property (p_fresh_wait) else $error("control before fresh values");
   property p_ext_dup;
      @(posedge clk) disable iff (!reset_n)
         (s_q.e_q2[1] && !s_q.e_q2[2]) |=> (external_error_code == CCM_EXT_DUP_IP);
   endproperty
   a_ext_dup: assert property (p_ext_dup) else $error("wrong duplicate ip code");
   property p_ext_addr;
      @(posedge clk) disable iff (!reset_n)
         (s_q.e_q2[0] && !s_q.e_q2[1] && !s_q.e_q2[2]) |=> (external_error_code == CCM_EXT_ADDR_SRV);
   endproperty
   a_ext_addr: assert property (p_ext_addr) else $error("wrong address server code");
   property p_eth_overload;
      @(posedge clk) disable iff (!reset_n)
         (s_q.supervised[CCM_ETH_CH] && s_q.e_q2[4]) |=> s_q.interrupt;
   endproperty
   a_eth_overload: assert property (p_eth_overload) else $error("overload did not interrupt");
   property p_enable_written;
      @(posedge clk) disable iff (!reset_n)
         $rose(s_q.enabled[CCM_ETH_CH]) |-> (($past(s_q.involved) & ~s_q.written[CCM_ETH_CH]) == '0);
   endproperty
   a_enable_written: assert property (p_enable_written) else $error("enabled before all written");
   property p_react_latch;
      @(posedge clk) disable iff (!reset_n)
         (|intr_src) |=> (comm_reaction == $past(s_q.reaction_cfg));
   endproperty
   a_react_latch: assert property (p_react_latch) else $error("reaction not taken");
   property p_cause_set;
      @(posedge clk) disable iff (!reset_n)
         (s_q.interrupt && s_q.e_q2[3]) |=> (ethernet_interruption_cause == CCM_CAUSE_TIMEOUT);
   endproperty
   a_cause_set: assert property (p_cause_set) else $error("timeout cause missing");
   property p_cause_clear;
      @(posedge clk) disable iff (!reset_n)
         !(s_q.interrupt && s_q.e_q2[3]) |=> (ethernet_interruption_cause == CCM_CAUSE_NONE);
   endproperty
   a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared");
   property p_local_copy;
      @(posedge clk) disable iff (!reset_n)
         (s_q.run == CCM_RUN_LOCAL && !s_q.fl_q2) |=>
            ((s_q.par[$past(s_q.active_ch)][1] == $past(local_ref_freq))
            && (s_q.par[$past(s_q.active_ch)][0] == {14'h0000, $past(local_run_rev), $past(local_run_fwd)}));
   endproperty
   a_local_copy: assert property (p_local_copy) else $error("local values not copied");
endmodule : ccm_monitor

/* File: verif/ccm_ctrl_model.sv */
// network controller model: writes control word and references into the drive
`timescale 1ns/100ps
module ccm_ctrl_model (
   input wire logic clk,
   input wire logic reset_n,
   output logic par_wr,
   output logic [1:0] par_ch,
   output logic [2:0] par_idx,
   output logic [15:0] par_data
);
   initial begin
      par_wr = 1'b0;
      par_ch = 2'h0;
      par_idx = 3'h0;
      par_data = 16'h5a5a;
   end

   // command and reference writes
   // a slow controller waits gap cycles; data does not linger after the strobe
   task automatic write_par(input logic [1:0] ch, input logic [2:0] idx, input logic [15:0] d, input int gap);
      // a controller held in reset writes nothing
      while (!reset_n) @(posedge clk);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      par_wr <= 1'b1;
      par_ch <= ch;
      par_idx <= idx;
      par_data <= d;
      @(posedge clk);
      par_wr <= 1'b0;
      par_data <= ~d;
   endtask : write_par
endmodule : ccm_ctrl_model

/* File: verif/ccm_monitor_tb.sv */
// self-checking bench for the channel monitor
`timescale 1ns/100ps
module ccm_monitor_tb
   import ccm_pkg::*;
   ;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic par_wr;
   logic [1:0] par_ch, comm_reaction;
   logic [2:0] par_idx;
   logic [15:0] par_data, ethernet_control_word, reference_frequency;
   logic [15:0] local_ref_freq = 16'h0;
   logic eth_addr_srv_fail = 1'b0, eth_dup_ip = 1'b0, eth_bad_ip = 1'b0;
   logic eth_word_timeout = 1'b0, eth_overload = 1'b0, forced_local = 1'b0;
   logic local_run_fwd = 1'b0, local_run_rev = 1'b0, start_req = 1'b0;
   logic [3:0] ch_warning = 4'h0, ethernet_interruption_cause, external_error_code;
   logic start_allowed, comm_interrupt, channel_control, irq;
   int bad_count = 0;
   int tests_run = 0;

   ccm_ctrl_model u_ctrl (.clk(clk), .reset_n(reset_n), .par_wr(par_wr), .par_ch(par_ch),
      .par_idx(par_idx), .par_data(par_data));
   ccm_monitor u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .par_wr(par_wr), .par_ch(par_ch),
      .par_idx(par_idx), .par_data(par_data), .eth_addr_srv_fail(eth_addr_srv_fail),
      .eth_dup_ip(eth_dup_ip), .eth_bad_ip(eth_bad_ip), .eth_word_timeout(eth_word_timeout),
      .eth_overload(eth_overload), .ch_warning(ch_warning), .forced_local(forced_local),
      .local_run_fwd(local_run_fwd), .local_run_rev(local_run_rev), .local_ref_freq(local_ref_freq),
      .start_req(start_req), .start_allowed(start_allowed), .comm_interrupt(comm_interrupt),
      .comm_reaction(comm_reaction), .channel_control(channel_control),
      .ethernet_control_word(ethernet_control_word), .reference_frequency(reference_frequency),
      .ethernet_interruption_cause(ethernet_interruption_cause),
      .external_error_code(external_error_code), .irq(irq));

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic end_of_test();
      if (bad_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & m, e);
   endtask : rchk

   // warnings pass a two-flop synchroniser, so allow a few edges
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc

   initial begin
      #20000;
      bad_count++;
      end_of_test();
   end

   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rchk(CCM_ADDR_STATUS, 32'hfff, 32'h0);
      rchk(CCM_ADDR_INVOLVED, 32'hff, 32'h3);
      rchk(8'hfc, 32'hffffffff, 32'h0);
      wr(CCM_ADDR_CTRL, 32'h83);
      wr(CCM_ADDR_IRQ_ENABLE, 32'h7);
      wr(CCM_ADDR_REACTION, 32'h1);
      // unsupervised channels warn; external codes in turn
      ch_warning <= 4'h1;
      eth_overload <= 1'b1;
      eth_bad_ip <= 1'b1;
      wait_cyc(6);
      chk(32'(comm_interrupt), 32'h0);
      chk(32'(external_error_code), 32'h1);
      eth_bad_ip <= 1'b0;
      eth_dup_ip <= 1'b1;
      wait_cyc(6);
      chk(32'(external_error_code), 32'h2);
      eth_dup_ip <= 1'b0;
      eth_addr_srv_fail <= 1'b1;
      wait_cyc(6);
      chk(32'(external_error_code), 32'h4);
      rchk(CCM_ADDR_CODES, 32'hff, 32'h40);
      chk(32'(comm_interrupt), 32'h0);
      {eth_addr_srv_fail, eth_overload, ch_warning} <= 6'h0;
      start_req <= 1'b1;
      wait_cyc(6);
      chk(32'(start_allowed), 32'h0);
      u_ctrl.write_par(2'h3, 3'h0, 16'h000f, 0);
      wait_cyc(2);
      rchk(CCM_ADDR_STATUS, 32'h808, 32'h008);
      chk(32'(start_allowed), 32'h0);
      u_ctrl.write_par(2'h3, 3'h1, 16'd500, 3);
      wait_cyc(3);
      rchk(CCM_ADDR_STATUS, 32'h808, 32'h808);
      chk(32'(start_allowed), 32'h1);
      chk(32'(reference_frequency), 32'd500);
      chk(32'(ethernet_control_word), 32'h000f);
      // supervised channel times out
      eth_word_timeout <= 1'b1;
      wait_cyc(6);
      chk(32'(comm_interrupt), 32'h1);
      chk(32'(comm_reaction), 32'h1);
      chk(32'(ethernet_interruption_cause), 32'h1);
      chk(32'(irq), 32'h1);
      rchk(CCM_ADDR_IRQ_STATUS, 32'h1, 32'h1);
      rchk(CCM_ADDR_CTRL, 32'h100, 32'h100);
      rchk(CCM_ADDR_REACTION, 32'h3, 32'h1);
      rchk(CCM_ADDR_STATUS, 32'h800, 32'h0);
      eth_word_timeout <= 1'b0;
      wait_cyc(6);
      wr(CCM_ADDR_CTRL, 32'h183);
      wr(CCM_ADDR_IRQ_CLEAR, 32'h7);
      wait_cyc(2);
      chk(32'(comm_interrupt), 32'h0);
      chk(32'(ethernet_interruption_cause), 32'h0);
      chk(32'(irq), 32'h0);
      // forced local and its exit
      u_ctrl.write_par(2'h3, 3'h0, 16'h000f, 0);
      u_ctrl.write_par(2'h3, 3'h1, 16'd500, 0);
      local_run_fwd <= 1'b1;
      local_ref_freq <= 16'h0123;
      forced_local <= 1'b1;
      wait_cyc(6);
      rchk(CCM_ADDR_STATUS, 32'h800, 32'h0);
      forced_local <= 1'b0;
      wait_cyc(6);
      chk(32'(ethernet_control_word), 32'h0001);
      chk(32'(reference_frequency), 32'h0123);
      chk(32'(channel_control), 32'h0);
      rchk(CCM_ADDR_REF_FREQ, 32'hffff, 32'h0123);
      rchk(CCM_ADDR_CTRL_WORD, 32'hffff, 32'h0001);
      u_ctrl.write_par(2'h3, 3'h0, 16'h000f, 0);
      u_ctrl.write_par(2'h3, 3'h1, 16'd250, 0);
      wait_cyc(4);
      chk(32'(channel_control), 32'h1);
      end_of_test();
   end
endmodule : ccm_monitor_tb
